// >>> src/thd_alarm_supervisor.sv
// Harmonic distortion alarm supervisor with APB registers, events and record log
//
// Notes on behaviour
// - Block sampled at each cycle start
// - Pickup without block asserts start, timer
// - Pickup under block asserts blocked only
// - Block clears start like pickup release
// - Three delay timers, 5 ms steps
// - Condition: normal, start, alarm or blocked
// - Reports five operating behaviour values
// - Fourteen assert/deassert status events
// - Per-event select of on/off edges
// - Events carry capture time stamp
// - Clearable start, alarm, blocked counters
// - Twelve-entry log on assert edges
// - Entry: time, event, phases, group
// - Outputs drive relays and logic
// - Any phase over setting picks up
// - Release below 97 percent of setting
// - One amplitude/power selector for all
`timescale 1ns/1ps
`include "thd_defines.svh"
module thd_alarm_supervisor import thd_pkg::*; #(
	parameter int PROC_CYCLES = `PROC_CYCLE_CYCLES
) (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        block_pin_in,
	input  wire logic [13:0] amp_l1_in,
	input  wire logic [13:0] amp_l2_in,
	input  wire logic [13:0] amp_l3_in,
	input  wire logic [13:0] amp_r1_in,
	input  wire logic [13:0] amp_r2_in,
	input  wire logic [13:0] pow_l1_in,
	input  wire logic [13:0] pow_l2_in,
	input  wire logic [13:0] pow_l3_in,
	input  wire logic [13:0] pow_r1_in,
	input  wire logic [13:0] pow_r2_in,
	input  wire logic [63:0] time_stamp_in,
	input  wire logic [2:0]  setting_group_in,
	input  wire logic        test_mode_in,
	output logic [2:0]       start_out,
	output logic [2:0]       alarm_out,
	output logic             blocked_out,
	output logic [3:0]       monitor_condition_out,
	output logic [2:0]       node_behaviour_status_out,
	output logic             event_valid_out,
	output logic [3:0]       event_id_out,
	output logic [63:0]      event_time_out,
	output logic             irq_out
);
	localparam int LW = $clog2(`LOG_DEPTH);
	logic [2:0]  block_sync_reg;
	logic        block_level_reg;
	logic [31:0] cycle_cnt_reg;
	logic        tick;
	logic        block_reg;
	logic [2:0]  ctrl_reg;
	logic        power_sel_reg;
	logic [2:0]  mode_reg;
	logic [13:0] pickup_reg [3];
	logic [18:0] delay_reg [3];
	logic [27:0] evt_sel_reg;
	logic [31:0] cnt_start_reg, cnt_alarm_reg, cnt_block_reg;
	logic [13:0] irq_stat_reg, irq_en_reg;
	logic [LW-1:0] log_idx_reg, log_wptr_reg;
	logic [13:0] status_now, status_prev_reg, rise, fall, evt_hit, evt_pending_reg, evt_next;
	logic [63:0] evt_time_reg [14];
	logic [13:0] sel_l [3], sel_r1, sel_r2;
	logic [2:0]  ch_blocked;
	logic        eff_block, eff_off;
	logic        access, wr, rd;
	logic [127:0] log_wdata, log_rdata;
	logic        log_we;
	logic [3:0]  log_id;
	logic [31:0] rdata;
	logic [13:0] irq_clr;
	node_mode_t  mode_eff;

	// Pin passes three flops; change taken when last two agree
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			block_sync_reg  <= 3'h0;
			block_level_reg <= 1'b0;
		end else begin
			block_sync_reg <= {block_sync_reg[1:0], block_pin_in};
			if (block_sync_reg[2] == block_sync_reg[1])
				block_level_reg <= block_sync_reg[1];
		end
	end

	assign tick = (cycle_cnt_reg == 32'(PROC_CYCLES - 1));
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			cycle_cnt_reg <= 32'h0000_0000;
		else
			cycle_cnt_reg <= tick ? 32'h0000_0000 : cycle_cnt_reg + 32'h0000_0001;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			block_reg <= 1'b0;
		else if (cycle_cnt_reg == 32'h0000_0000)
			block_reg <= block_level_reg;
	end

	always_comb begin
		mode_eff = node_mode_t'(mode_reg);
		if (mode_reg == MODE_ON && test_mode_in)
			mode_eff = MODE_TEST;
		else if (mode_reg == MODE_BLOCKED && test_mode_in)
			mode_eff = MODE_TEST_BLOCKED;
		else if (mode_reg > MODE_OFF)
			mode_eff = MODE_OFF;
	end
	assign node_behaviour_status_out = mode_eff;
	assign eff_off   = (mode_eff == MODE_OFF);
	assign eff_block = block_reg | (mode_eff == MODE_BLOCKED) | (mode_eff == MODE_TEST_BLOCKED);

	assign sel_l[0] = power_sel_reg ? pow_l1_in : amp_l1_in;
	assign sel_l[1] = power_sel_reg ? pow_l2_in : amp_l2_in;
	assign sel_l[2] = power_sel_reg ? pow_l3_in : amp_l3_in;
	assign sel_r1   = power_sel_reg ? pow_r1_in : amp_r1_in;
	assign sel_r2   = power_sel_reg ? pow_r2_in : amp_r2_in;

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_ch
			thd_channel u_ch (
				.clk_in      (clk_in),
				.rst_n_in    (rst_n_in),
				.tick_in     (tick),
				.block_in    (eff_block),
				.alarm_en_in (ctrl_reg[g] & ~eff_off),
				.pickup_in   (pickup_reg[g]),
				.delay_in    (delay_reg[g]),
				.value0_in   (g == 0 ? sel_l[0] : (g == 1 ? sel_r1 : sel_r2)),
				.value1_in   (g == 0 ? sel_l[1] : (g == 1 ? sel_r1 : sel_r2)),
				.value2_in   (g == 0 ? sel_l[2] : (g == 1 ? sel_r1 : sel_r2)),
				.pickup_out  (),
				.start_out   (start_out[g]),
				.alarm_out   (alarm_out[g]),
				.blocked_out (ch_blocked[g])
			);
		end
	endgenerate
	assign blocked_out = |ch_blocked;

	always_comb begin
		if (blocked_out)
			monitor_condition_out = COND_BLOCKED;
		else if (|alarm_out)
			monitor_condition_out = COND_ALARM;
		else if (|start_out)
			monitor_condition_out = COND_START;
		else
			monitor_condition_out = COND_NORMAL;
	end

	assign status_now = {blocked_out, blocked_out, alarm_out[2], alarm_out[2], alarm_out[1], alarm_out[1],
		alarm_out[0], alarm_out[0], start_out[2], start_out[2], start_out[1], start_out[1],
		start_out[0], start_out[0]};
	assign rise = status_now & ~status_prev_reg & 14'h1555;
	assign fall = ~status_now & status_prev_reg & 14'h2AAA;
	assign evt_hit = (rise & evt_sel_reg[13:0]) | (fall & evt_sel_reg[27:14]);
	always_comb begin
		evt_next = evt_pending_reg | evt_hit;
		for (int i = 0; i < 14; i++) begin
			if (evt_pending_reg[i] && (evt_pending_reg & ((14'h0001 << i) - 14'h0001)) == 14'h0000)
				evt_next[i] = evt_hit[i];
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			status_prev_reg <= 14'h0000;
			evt_pending_reg <= 14'h0000;
			event_valid_out <= 1'b0;
			event_id_out    <= 4'h0;
			event_time_out  <= 64'h0;
		end else begin
			status_prev_reg <= status_now;
			evt_pending_reg <= evt_next;
			event_valid_out <= |evt_pending_reg;
			for (int i = 13; i >= 0; i--) begin
				if (evt_pending_reg[i]) begin
					event_id_out   <= 4'(i);
					event_time_out <= evt_time_reg[i];
				end
			end
		end
	end
	always_ff @(posedge clk_in) begin
		for (int i = 0; i < 14; i++) begin
			if (evt_hit[i])
				evt_time_reg[i] <= time_stamp_in;
		end
	end

	assign log_we = |(rise & 14'h1555);
	always_comb begin
		log_id = 4'h0;
		for (int i = 13; i >= 0; i--) begin
			if (rise[i])
				log_id = 4'(i);
		end
	end
	assign log_wdata = {15'h0000, setting_group_in, log_id, sel_l[2], sel_l[1], sel_l[0], time_stamp_in};
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			log_wptr_reg <= '0;
		else if (log_we)
			log_wptr_reg <= (log_wptr_reg == LW'(`LOG_DEPTH - 1)) ? '0 : log_wptr_reg + 1'b1;
	end
	thd_log_mem #(.WIDTH(128), .DEPTH(`LOG_DEPTH)) u_log (
		.clk_in      (clk_in),
		.wr_en_in    (log_we),
		.wr_addr_in  (log_wptr_reg),
		.wr_data_in  (log_wdata),
		.rd_addr_in  (log_idx_reg),
		.rd_data_out (log_rdata)
	);

	// APB: zero-wait, unmapped answers with slverr
	assign access      = psel_in & penable_in;
	assign wr          = access & pwrite_in;
	assign rd          = access & ~pwrite_in;
	assign pready_out  = 1'b1;
	assign irq_clr     = (wr && paddr_in == `REG_IRQ_CLR) ? pwdata_in[13:0] : 14'h0000;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_reg      <= 3'h7;
			power_sel_reg <= 1'b0;
			mode_reg      <= 3'h0;
			pickup_reg    <= '{`PICKUP_DEFAULT, `PICKUP_DEFAULT, `PICKUP_DEFAULT};
			delay_reg     <= '{19'(`DELAY_DEFAULT), 19'(`DELAY_DEFAULT), 19'(`DELAY_DEFAULT)};
			evt_sel_reg   <= 28'hFFF_FFFF;
			irq_en_reg    <= 14'h0000;
			log_idx_reg   <= '0;
		end else if (wr) begin
			case (paddr_in)
				`REG_CTRL:      begin ctrl_reg <= pwdata_in[2:0]; power_sel_reg <= pwdata_in[4]; end
				`REG_MODE:      mode_reg <= pwdata_in[2:0];
				`REG_PICKUP_PH: pickup_reg[0] <= pwdata_in[13:0];
				`REG_PICKUP_R1: pickup_reg[1] <= pwdata_in[13:0];
				`REG_PICKUP_R2: pickup_reg[2] <= pwdata_in[13:0];
				`REG_DELAY_PH:  delay_reg[0] <= (pwdata_in[18:0] > `DELAY_MAX) ? `DELAY_MAX : pwdata_in[18:0];
				`REG_DELAY_R1:  delay_reg[1] <= (pwdata_in[18:0] > `DELAY_MAX) ? `DELAY_MAX : pwdata_in[18:0];
				`REG_DELAY_R2:  delay_reg[2] <= (pwdata_in[18:0] > `DELAY_MAX) ? `DELAY_MAX : pwdata_in[18:0];
				`REG_EVT_SEL:   evt_sel_reg <= pwdata_in[27:0];
				`REG_IRQ_EN:    irq_en_reg <= pwdata_in[13:0];
				`REG_LOG_IDX:   log_idx_reg <= (pwdata_in[LW-1:0] < LW'(`LOG_DEPTH)) ? pwdata_in[LW-1:0] : '0;
				default:        ;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_start_reg <= 32'h0000_0000;
			cnt_alarm_reg <= 32'h0000_0000;
			cnt_block_reg <= 32'h0000_0000;
		end else begin
			if (|(rise & 14'h0015))
				cnt_start_reg <= (wr && paddr_in == `REG_CNT_CLR && pwdata_in[0]) ? 32'h1 : cnt_start_reg + 32'h1;
			else if (wr && paddr_in == `REG_CNT_CLR && pwdata_in[0])
				cnt_start_reg <= 32'h0000_0000;
			if (|(rise & 14'h0540))
				cnt_alarm_reg <= (wr && paddr_in == `REG_CNT_CLR && pwdata_in[1]) ? 32'h1 : cnt_alarm_reg + 32'h1;
			else if (wr && paddr_in == `REG_CNT_CLR && pwdata_in[1])
				cnt_alarm_reg <= 32'h0000_0000;
			if (rise[12])
				cnt_block_reg <= (wr && paddr_in == `REG_CNT_CLR && pwdata_in[2]) ? 32'h1 : cnt_block_reg + 32'h1;
			else if (wr && paddr_in == `REG_CNT_CLR && pwdata_in[2])
				cnt_block_reg <= 32'h0000_0000;
		end
	end

	// Sticky interrupt status, new event wins over clear
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			irq_stat_reg <= 14'h0000;
		else
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | rise | fall;
	end
	assign irq_out = |(irq_stat_reg & irq_en_reg);

	always_comb begin
		pslverr_out = 1'b0;
		case (paddr_in)
			`REG_CTRL:      rdata = {27'h0, power_sel_reg, 1'b0, ctrl_reg};
			`REG_MODE:      rdata = {29'h0, mode_reg};
			`REG_PICKUP_PH: rdata = {18'h0, pickup_reg[0]};
			`REG_PICKUP_R1: rdata = {18'h0, pickup_reg[1]};
			`REG_PICKUP_R2: rdata = {18'h0, pickup_reg[2]};
			`REG_DELAY_PH:  rdata = {13'h0, delay_reg[0]};
			`REG_DELAY_R1:  rdata = {13'h0, delay_reg[1]};
			`REG_DELAY_R2:  rdata = {13'h0, delay_reg[2]};
			`REG_EVT_SEL:   rdata = {4'h0, evt_sel_reg};
			`REG_STATUS:    rdata = {18'h0, node_behaviour_status_out, monitor_condition_out, blocked_out,
				alarm_out, start_out};
			`REG_CNT_START: rdata = cnt_start_reg;
			`REG_CNT_ALARM: rdata = cnt_alarm_reg;
			`REG_CNT_BLOCK: rdata = cnt_block_reg;
			`REG_CNT_CLR:   rdata = 32'h0000_0000;
			`REG_IRQ_STAT:  rdata = {18'h0, irq_stat_reg};
			`REG_IRQ_EN:    rdata = {18'h0, irq_en_reg};
			`REG_IRQ_CLR:   rdata = 32'h0000_0000;
			`REG_LOG_IDX:   rdata = {{(32-LW){1'b0}}, log_idx_reg};
			`REG_LOG_TIME:  rdata = log_rdata[31:0];
			`REG_LOG_INFO:  rdata = {log_rdata[63:32]};
			`REG_LOG_PH12:  rdata = {4'h0, log_rdata[91:64]};
			`REG_LOG_PH3:   rdata = {11'h000, log_rdata[112:92]};
			`REG_LOG_WPTR:  rdata = {{(32-LW){1'b0}}, log_wptr_reg};
			default: begin
				rdata = 32'h0000_0000;
				pslverr_out = access;
			end
		endcase
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			prdata_out <= 32'h0000_0000;
		else if (psel_in && !penable_in && !pwrite_in)
			prdata_out <= rdata;
	end

	AST_COND_ONEHOT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$onehot(monitor_condition_out)) else $error("condition not one-hot");
	AST_LOG_WRAP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		log_we && log_wptr_reg == LW'(`LOG_DEPTH - 1) |=> log_wptr_reg == '0) else $error("log pointer no wrap");
	AST_CNT_START: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		|(rise & 14'h0015) && !wr |=> cnt_start_reg == $past(cnt_start_reg) + 32'h1) else $error("start count");
	AST_EVT_OUT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		|evt_hit |-> ##[1:30] event_valid_out) else $error("event lost");
endmodule

// >>> src/thd_channel.sv
// One pick-up element with hysteresis and definite-delay alarm timer
`timescale 1ns/1ps
`include "thd_defines.svh"
module thd_channel (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        tick_in,
	input  wire logic        block_in,
	input  wire logic        alarm_en_in,
	input  wire logic [13:0] pickup_in,
	input  wire logic [18:0] delay_in,
	input  wire logic [13:0] value0_in,
	input  wire logic [13:0] value1_in,
	input  wire logic [13:0] value2_in,
	output logic             pickup_out,
	output logic             start_out,
	output logic             alarm_out,
	output logic             blocked_out
);
	logic [20:0] thr_hi;
	logic [20:0] thr_lo;
	logic        over;
	logic        under;
	logic [18:0] timer_reg;
	assign thr_hi = {7'h00, pickup_in} * 21'd100;
	assign thr_lo = {7'h00, pickup_in} * 21'(`RESET_RATIO_PCT);
	assign over  = ({7'h00, value0_in} * 21'd100 > thr_hi) | ({7'h00, value1_in} * 21'd100 > thr_hi)
		| ({7'h00, value2_in} * 21'd100 > thr_hi);
	assign under = ({7'h00, value0_in} * 21'd100 < thr_lo) & ({7'h00, value1_in} * 21'd100 < thr_lo)
		& ({7'h00, value2_in} * 21'd100 < thr_lo);
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			pickup_out <= 1'b0;
		else if (tick_in) begin
			if (!alarm_en_in)
				pickup_out <= 1'b0;
			else if (over)
				pickup_out <= 1'b1;
			else if (under)
				pickup_out <= 1'b0;
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			start_out   <= 1'b0;
			blocked_out <= 1'b0;
			alarm_out   <= 1'b0;
			timer_reg   <= 19'h0_0000;
		end else if (tick_in) begin
			start_out   <= pickup_out & ~block_in & (start_out | ~blocked_out);
			blocked_out <= pickup_out & (blocked_out | (block_in & ~start_out) | block_in);
			if (!(pickup_out & ~block_in)) begin
				timer_reg <= 19'h0_0000;
				alarm_out <= 1'b0;
			end else if (start_out) begin
				if (timer_reg + 19'h0_0001 >= delay_in)
					alarm_out <= 1'b1;
				else
					timer_reg <= timer_reg + 19'h0_0001;
			end
		end
	end
	AST_ALARM_NEEDS_START: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		alarm_out |-> start_out) else $error("alarm without start");
	AST_BLOCK_EXCL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!(blocked_out && start_out)) else $error("blocked and start together");
	AST_BLOCK_CLEARS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		tick_in && block_in |=> !start_out && !alarm_out) else $error("start survived block");
	AST_HYST: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		tick_in && alarm_en_in && !under |=> $past(pickup_out) ? pickup_out : 1'b1)
		else $error("pickup released above reset level");
endmodule

// >>> src/thd_defines.svh
// Constants of the harmonic distortion alarm supervisor
`ifndef THD_DEFINES_SVH
`define THD_DEFINES_SVH
`define CLK_MHZ            100
`define PROC_CYCLE_US      5000
`define PROC_CYCLE_CYCLES  (`PROC_CYCLE_US * `CLK_MHZ)
`define DELAY_STEP_MS      5
`define DELAY_DEFAULT      16'h07D0
`define DELAY_MAX          19'h5_7E40
`define PICKUP_DEFAULT     14'h03E8
`define RESET_RATIO_PCT    97
`define LOG_DEPTH          12
`define REG_CTRL           12'h000
`define REG_MODE           12'h004
`define REG_PICKUP_PH      12'h008
`define REG_PICKUP_R1      12'h00C
`define REG_PICKUP_R2      12'h010
`define REG_DELAY_PH       12'h014
`define REG_DELAY_R1       12'h018
`define REG_DELAY_R2       12'h01C
`define REG_EVT_SEL        12'h020
`define REG_STATUS         12'h024
`define REG_CNT_START      12'h028
`define REG_CNT_ALARM      12'h02C
`define REG_CNT_BLOCK      12'h030
`define REG_CNT_CLR        12'h034
`define REG_IRQ_STAT       12'h038
`define REG_IRQ_EN         12'h03C
`define REG_IRQ_CLR        12'h040
`define REG_LOG_IDX        12'h044
`define REG_LOG_TIME       12'h048
`define REG_LOG_INFO       12'h04C
`define REG_LOG_PH12       12'h050
`define REG_LOG_PH3        12'h054
`define REG_LOG_WPTR       12'h058
`endif

// >>> src/thd_log_mem.sv
// Twelve-entry record store with registered read data
`timescale 1ns/1ps
module thd_log_mem #(
	parameter int WIDTH = 128,
	parameter int DEPTH = 12
) (
	input  wire logic                     clk_in,
	input  wire logic                     wr_en_in,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
	input  wire logic [WIDTH-1:0]         wr_data_in,
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
	output logic      [WIDTH-1:0]         rd_data_out
);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	always_ff @(posedge clk_in) begin
		if (wr_en_in)
			mem_reg[wr_addr_in] <= wr_data_in;
		rd_data_out <= mem_reg[rd_addr_in];
	end
endmodule

// >>> src/thd_pkg.sv
// Types of the harmonic distortion alarm supervisor
package thd_pkg;
	typedef enum logic [3:0] {
		COND_NORMAL  = 4'h1,
		COND_START   = 4'h2,
		COND_ALARM   = 4'h4,
		COND_BLOCKED = 4'h8
	} monitor_condition_t;
	typedef enum logic [2:0] {
		MODE_ON = 3'h0, MODE_BLOCKED = 3'h1, MODE_TEST = 3'h2, MODE_TEST_BLOCKED = 3'h3, MODE_OFF = 3'h4
	} node_mode_t;
endpackage

// >>> verification/tb_thd_alarm_supervisor.sv
// Testbench of the distortion alarm supervisor
`timescale 1ns/1ps
`include "thd_defines.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
$display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module tb_thd_alarm_supervisor;
	import thd_pkg::*;
	localparam int P = 10;
	logic        clk, rst_n, psel, pen, pwr, blk_req, tmode, err, blk;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	logic [69:0] amp_req, pow_req, amp, pow;
	logic [63:0] tstamp, evt_time;
	logic [31:0] prdata;
	logic        pready, pslverr, blocked, evt_valid, irq;
	logic [2:0]  start, alarm, behav;
	logic [3:0]  cond, evt_id;
	logic [3:0]  evq[$];
	int          fails, compares, cycles;
	thd_front_model FM (.clk_in(clk), .rst_n_in(rst_n), .block_req_in(blk_req), .amp_req_in(amp_req),
		.pow_req_in(pow_req), .block_out(blk), .amp_out(amp), .pow_out(pow), .time_out(tstamp));
	thd_alarm_supervisor #(.PROC_CYCLES(P)) DUT (.clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .block_pin_in(blk), .amp_l1_in(amp[13:0]),
		.amp_l2_in(amp[27:14]), .amp_l3_in(amp[41:28]), .amp_r1_in(amp[55:42]), .amp_r2_in(amp[69:56]),
		.pow_l1_in(pow[13:0]), .pow_l2_in(pow[27:14]), .pow_l3_in(pow[41:28]), .pow_r1_in(pow[55:42]),
		.pow_r2_in(pow[69:56]), .time_stamp_in(tstamp), .setting_group_in(3'h5), .test_mode_in(tmode),
		.start_out(start), .alarm_out(alarm), .blocked_out(blocked), .monitor_condition_out(cond),
		.node_behaviour_status_out(behav), .event_valid_out(evt_valid), .event_id_out(evt_id),
		.event_time_out(evt_time), .irq_out(irq));
	initial clk = 1'b0;
	always #5 clk = ~clk;
	task end_of_test;
		$display("Counts: %0d compares, %0d fails", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Ceiling well above the roughly 800 cycles the tests take
	always @(posedge clk) begin
		cycles++;
		if (cycles > 8000) begin
			fails++;
			end_of_test();
		end
	end
	// Outputs are settled at the falling edge
	always @(negedge clk) begin
		if (evt_valid === 1'b1) begin
			evq.push_back(evt_id);
			`CHK((tstamp - evt_time) < 64'h28, 1'b1)
		end
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task ticks(input int n);
		repeat (n * P) @(posedge clk);
	endtask
	task set_amp(input int ch, input logic [13:0] v);
		@(posedge clk);
		amp_req[ch*14 +: 14] <= v;
	endtask
	task wait_start(input int ch);
		int n;
		n = 0;
		while (start[ch] !== 1'b1 && n < 4 * P) begin
			@(posedge clk);
			n++;
		end
	endtask
	task chk_evt(input logic [3:0] e);
		logic [3:0] g;
		g = (evq.size() > 0) ? evq.pop_front() : 4'hF;
		`CHK(g, e)
	endtask
	initial begin
		{psel, pen, pwr, blk_req, tmode, rst_n} = '0;
		paddr = '0;
		pwdata = '0;
		amp_req = '0;
		pow_req = '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		`CHK(cond, COND_NORMAL)
		`CHK({start, alarm, blocked, irq}, 8'h00)
		`CHK(behav, MODE_ON)
		apb(1'b0, `REG_CTRL, 32'h0);
		`CHK(rd[4:0], 5'h07)
		apb(1'b0, `REG_EVT_SEL, 32'h0);
		`CHK(rd[27:0], 28'hFFFFFFF)
		apb(1'b0, 12'h100, 32'h0);
		`CHK(err, 1'b1)
		$display("Test reset done");
		apb(1'b1, `REG_DELAY_PH, 32'h3);
		set_amp(1, 14'h03E9);
		wait_start(0);
		`CHK(start[0], 1'b1)
		`CHK(cond, COND_START)
		ticks(2);
		`CHK(alarm[0], 1'b0)
		ticks(3);
		`CHK(alarm[0], 1'b1)
		`CHK(cond, COND_ALARM)
		set_amp(1, 14'h03CA);
		ticks(3);
		`CHK(start[0], 1'b1)
		set_amp(1, 14'h03C9);
		ticks(3);
		`CHK({start[0], alarm[0]}, 2'b00)
		chk_evt(4'h0);
		chk_evt(4'h6);
		chk_evt(4'h1);
		chk_evt(4'h7);
		$display("Test alarm done");
		set_amp(1, 14'h03E9);
		wait_start(0);
		blk_req <= 1'b1;
		ticks(3);
		`CHK({start[0], alarm[0]}, 2'b00)
		set_amp(1, 14'h03C9);
		ticks(3);
		set_amp(1, 14'h03E9);
		ticks(3);
		`CHK({blocked, start[0]}, 2'b10)
		`CHK(cond, COND_BLOCKED)
		blk_req <= 1'b0;
		set_amp(1, 14'h03C9);
		ticks(3);
		apb(1'b0, `REG_CNT_START, 32'h0);
		`CHK(rd, 32'h2)
		apb(1'b0, `REG_CNT_ALARM, 32'h0);
		`CHK(rd, 32'h1)
		apb(1'b0, `REG_CNT_BLOCK, 32'h0);
		`CHK(rd, 32'h2)
		apb(1'b1, `REG_CNT_CLR, 32'h7);
		apb(1'b0, `REG_CNT_START, 32'h0);
		`CHK(rd, 32'h0)
		$display("Test blocking done");
		evq.delete();
		apb(1'b1, `REG_CTRL, 32'h5);
		apb(1'b1, `REG_DELAY_R1, 32'h1);
		apb(1'b1, `REG_EVT_SEL, 32'h3FFF);
		set_amp(3, 14'h03E9);
		ticks(3);
		// Disabled element never picks up
		`CHK(start[1], 1'b0)
		apb(1'b1, `REG_CTRL, 32'h7);
		wait_start(1);
		`CHK(start[1], 1'b1)
		ticks(2);
		`CHK(alarm[1], 1'b1)
		set_amp(3, 14'h03C9);
		ticks(3);
		chk_evt(4'h2);
		chk_evt(4'h8);
		`CHK(evq.size(), 0)
		$display("Test event select done");
		apb(1'b1, `REG_IRQ_EN, 32'h0);
		apb(1'b1, `REG_IRQ_CLR, 32'hFFFFFFFF);
		apb(1'b1, `REG_CTRL, 32'h17);
		@(posedge clk);
		pow_req[69:56] <= 14'h03E9;
		wait_start(2);
		`CHK(start[2], 1'b1)
		`CHK(irq, 1'b0)
		apb(1'b0, `REG_IRQ_STAT, 32'h0);
		`CHK(rd != 32'h0, 1'b1)
		apb(1'b1, `REG_IRQ_EN, 32'hFFFFFFFF);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1)
		apb(1'b1, `REG_IRQ_CLR, 32'hFFFFFFFF);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		apb(1'b1, `REG_CTRL, 32'h7);
		ticks(3);
		`CHK(start[2], 1'b0)
		// Five more starts take the log past twelve entries
		repeat (5) begin
			set_amp(1, 14'h03E9);
			wait_start(0);
			set_amp(1, 14'h03C9);
			ticks(3);
		end
		apb(1'b0, `REG_LOG_WPTR, 32'h0);
		`CHK(rd, 32'h0000_0001)
		apb(1'b1, `REG_LOG_IDX, 32'h3);
		apb(1'b0, `REG_LOG_PH3, 32'h0);
		`CHK(rd, 32'h0017_0000)
		apb(1'b0, `REG_LOG_PH12, 32'h0);
		`CHK(rd, 32'h00FA_4000)
		tmode <= 1'b1;
		ticks(1);
		`CHK(behav, MODE_TEST)
		apb(1'b1, `REG_MODE, 32'h1);
		@(negedge clk);
		`CHK(behav, MODE_TEST_BLOCKED)
		apb(1'b1, `REG_MODE, 32'h4);
		@(negedge clk);
		`CHK(behav, MODE_OFF)
		$display("Test power and interrupt done");
		end_of_test();
	end
endmodule

// >>> verification/thd_front_model.sv
// Behavioural model of the blocking matrix and distortion front end
`timescale 1ns/1ps
module thd_front_model (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        block_req_in,
	input  wire logic [69:0] amp_req_in,
	input  wire logic [69:0] pow_req_in,
	output logic             block_out,
	output logic      [69:0] amp_out,
	output logic      [69:0] pow_out,
	output logic      [63:0] time_out
);
	// block request registered, reaching the pin one clock later
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			block_out <= 1'b0;
		end else begin
			block_out <= block_req_in;
		end
	end
	// Values change only on the clock, like a sampled measurement
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			amp_out <= '0;
			pow_out <= '0;
		end else begin
			amp_out <= amp_req_in;
			pow_out <= pow_req_in;
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			time_out <= 64'h0;
		end else begin
			time_out <= time_out + 64'h1;
		end
	end
endmodule
